// file: design/hlc_link_ctrl.sv
`default_nettype none
module hlc_link_ctrl #(
   parameter int DEPTH = hlc_pkg::FIFO_DEPTH  // bytes per fifo
) (
   input  wire logic       mclk_in,          // 40 MHz clock
   input  wire logic       sys_rst_in,       // sync reset, high
   input  wire logic [8:0] reg_addr_in,      // register address
   input  wire logic [7:0] reg_wdata_in,     // write data
   input  wire logic       reg_wr_in,        // write strobe
   input  wire logic       reg_rd_in,        // read strobe
   output var  logic [7:0] reg_rdata_out,    // read data, next cycle
   output var  logic       irq_n_out,        // interrupt, low active
   input  wire logic       e1_mode_in,       // 1 E1, 0 T1
   input  wire logic       bit_stb_in,       // one line bit time
   input  wire logic [4:0] slot_in,          // current time slot
   input  wire logic [2:0] bit_pos_in,       // bit within slot
   input  wire logic [3:0] sa_num_in,        // 4..8 on Sa bit, else 0
   input  wire logic       fdl_in,           // T1 facility link bit
   input  wire logic       rx_line_bit_in,   // received line bit
   output var  logic       tx_line_bit_out,  // bit to insert
   output var  logic       tx_line_own_out   // bit belongs to us
);
   localparam int AW = $clog2(DEPTH);
   // refuse depths the pointer arithmetic cannot serve
   if (DEPTH < 4 || DEPTH > 64 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two from 4 to 64");
   end

   typedef enum logic [2:0] {TS_IDLE, TS_DATA, TS_CRC1, TS_CRC2} hlc_tx_state_type;

   // complete block state, one register
   typedef struct packed {
      logic [DEPTH-1:0][8:0] rxm;   // rx bytes, bit 8 ends packet
      logic [AW-1:0]  rxw, rxr;     // rx pointers
      logic [AW:0]    rxc;          // rx level
      logic [DEPTH-1:0][8:0] txm;   // tx bytes, bit 8 ends packet
      logic [AW-1:0]  txw, txr;     // tx pointers
      logic [AW:0]    txc;          // tx level
      logic [7:0] rctl, rbs, rfc, rim, tc1, tbs, tc2, tfc, tim;
      logic [7:0] rls, tls;         // latched status
      logic [7:0] rack, tack;       // latched bits already read
      logic [2:0] rones;            // rx run of ones
      logic [7:0] rbyte;            // rx byte assembler
      logic [2:0] rbits;            // bits in assembler
      logic [15:0] rcrc;            // rx crc over whole bytes
      logic       rin;              // inside a frame
      logic       ovr_hold;         // dropping after overrun
      logic [2:0][7:0] hold;        // last three bytes, [0] newest
      logic [1:0] hn;               // valid bytes in hold
      logic       hwm_prev;         // previous rx watermark level
      logic       lwm_prev;         // previous tx watermark level
      logic [7:0] tsh;              // tx shifter, lsb first
      logic [3:0] tn;               // bits left in shifter
      logic       tstuff;           // shifter content is stuffed
      logic [2:0] tones;            // tx run of ones
      logic [15:0] tcrc;            // tx crc
      hlc_tx_state_type tst;        // tx framing state
      logic [7:0] rdat;             // read data
      logic       irq_n;
      logic       tbit, town;       // line outputs
   } hlc_state_type;

   hlc_state_type s, n;
   logic [7:0] ev_r, ev_t;           // one-cycle event pulses
   logic       rsel, tsel;           // this bit is ours
   logic       hwm_now, lwm_now;     // present watermark levels

   // byte-wise crc, lsb first
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ hlc_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // does this line bit belong to the controller
   function automatic logic pick(input logic [7:0] ctl, input logic [7:0] sup);
      logic [2:0] k;
      k = 3'(sa_num_in - 4'd4);
      if (!ctl[hlc_pkg::B_MAPSEL])
         return slot_in == ctl[4:0] && !sup[bit_pos_in];
      if (e1_mode_in)
         return sa_num_in >= 4'd4 && sa_num_in <= 4'd8 && !sup[k];
      return fdl_in;
   endfunction

   // a process, so the slot inputs read inside pick are in its sensitivity
   always_comb begin
      rsel = bit_stb_in && pick(s.rctl, s.rbs);
      tsel = bit_stb_in && pick(s.tc2, s.tbs);
   end
   assign hwm_now = s.rxc > {1'b0, s.rfc[AW-1:0]};
   assign lwm_now = s.txc < {1'b0, s.tfc[AW-1:0]};

   // next state
   always_comb begin
      logic       push, pend, pop, tpush, tpop, fnd, b;
      logic [7:0] pb, sh;
      logic [AW:0] cnt;
      logic [AW-1:0] ix;
      logic [3:0] tcnt;
      logic       st;
      n = s;
      ev_r = '0;
      ev_t = '0;
      push = 1'b0;
      pend = 1'b0;
      pop = 1'b0;
      tpush = 1'b0;
      tpop = 1'b0;
      pb = '0;
      b = rx_line_bit_in;
      cnt = '0;
      fnd = 1'b0;
      ix = '0;
      sh = s.tsh;
      tcnt = s.tn;
      st = s.tstuff;
      // bytes readable up to the first packet end
      for (int i = 0; i < DEPTH; i++) begin
         ix = AW'(s.rxr + AW'(i));
         if (i < s.rxc && !fnd) begin
            cnt = cnt + (AW+1)'(1);  // full width, a whole fifo counts 64
            fnd = s.rxm[ix][8];
         end
      end
      // receive engine
      if (rsel) begin
         if (b && s.rones == 3'd6) begin
            // seventh one: abort, close any open packet
            if (s.rin && s.hn != 2'd0) ev_r[hlc_pkg::R_ABT] = 1'b1;
            push = s.rin && s.hn == 2'd3;
            pend = 1'b1;
            pb = s.hold[2];
            n.rin = 1'b0;
            n.rones = 3'd7;
         end else if (b) begin
            if (s.rones != 3'd7) n.rones = s.rones + 3'd1;
         end else begin
            n.rones = 3'd0;
         end
         if (!b && s.rones == 3'd6) begin
            // flag: six spurious bits sit in the assembler
            if (s.rin && s.hn != 2'd0) begin
               if (s.rbits == 3'd6 && s.hn == 2'd3 && s.rcrc == hlc_pkg::CRC_GOOD)
                  ev_r[hlc_pkg::R_END] = 1'b1;
               else
                  ev_r[hlc_pkg::R_CRC] = 1'b1;
            end
            push = s.rin && s.hn == 2'd3;
            pend = 1'b1;
            pb = s.hold[2];
            n.rin = 1'b1;
            n.ovr_hold = 1'b0;
            n.rbits = 3'd0;
            n.hn = 2'd0;
            n.rcrc = hlc_pkg::CRC_INIT;
         end else if (s.rin && ((b && s.rones < 3'd5) || (!b && s.rones < 3'd5))) begin
            // payload bit; a zero after five ones is dropped
            n.rbyte = {b, s.rbyte[7:1]};
            n.rbits = s.rbits + 3'd1;
            if (s.rbits == 3'd7) begin
               n.rcrc = crc8(s.rcrc, {b, s.rbyte[7:1]});
               n.hold = {s.hold[1], s.hold[0], b, s.rbyte[7:1]};
               n.hn = (s.hn == 2'd3) ? 2'd3 : s.hn + 2'd1;
               if (s.hn == 2'd0) ev_r[hlc_pkg::R_STRT] = 1'b1;
               push = s.hn == 2'd3;  // keep fcs bytes out of the fifo
               pb = s.hold[2];
            end
         end
      end
      // host reads and writes
      if (reg_rd_in) begin
         case (reg_addr_in)
            hlc_pkg::A_RCTL: n.rdat = s.rctl;
            hlc_pkg::A_RBS:  n.rdat = s.rbs;
            hlc_pkg::A_RFC:  n.rdat = s.rfc;
            hlc_pkg::A_RLS: begin
               n.rdat = s.rls;
               n.rack = s.rack | s.rls;
            end
            hlc_pkg::A_RIM:  n.rdat = s.rim;
            hlc_pkg::A_RRT:  n.rdat = {2'b00, s.ovr_hold, 3'b000, hwm_now, s.rxc != 0};
            hlc_pkg::A_RPBA: n.rdat = {!fnd && cnt != 0, 7'(cnt)};
            hlc_pkg::A_RFD: begin
               n.rdat = s.rxm[s.rxr][7:0];
               pop = s.rxc != 0;
            end
            hlc_pkg::A_TC1:  n.rdat = s.tc1;
            hlc_pkg::A_TBS:  n.rdat = s.tbs;
            hlc_pkg::A_TC2:  n.rdat = s.tc2;
            hlc_pkg::A_TFC:  n.rdat = s.tfc;
            hlc_pkg::A_TLS: begin
               n.rdat = s.tls;
               n.tack = s.tack | s.tls;
            end
            hlc_pkg::A_TIM:  n.rdat = s.tim;
            hlc_pkg::A_TRT:  n.rdat = {6'b0, lwm_now, s.txc == 0};
            hlc_pkg::A_TAVL: n.rdat = 8'(DEPTH - s.txc);
            default:         n.rdat = 8'h00;
         endcase
      end
      if (reg_wr_in) begin
         case (reg_addr_in)
            hlc_pkg::A_RCTL: n.rctl = reg_wdata_in;
            hlc_pkg::A_RBS: n.rbs = reg_wdata_in;
            hlc_pkg::A_RFC: n.rfc = reg_wdata_in;
            hlc_pkg::A_RLS: n.rls = s.rls & ~reg_wdata_in;
            hlc_pkg::A_RIM: n.rim = reg_wdata_in;
            hlc_pkg::A_TC1: n.tc1 = reg_wdata_in;
            hlc_pkg::A_TBS: n.tbs = reg_wdata_in;
            hlc_pkg::A_TC2: n.tc2 = reg_wdata_in;
            hlc_pkg::A_TFC: n.tfc = reg_wdata_in;
            hlc_pkg::A_TLS: n.tls = s.tls & ~reg_wdata_in;
            hlc_pkg::A_TIM: n.tim = reg_wdata_in;
            hlc_pkg::A_TFD: begin
               // a full fifo drops the byte; the host must watch the free count
               tpush = s.txc != (AW+1)'(DEPTH);
               n.tc1[hlc_pkg::B_TXEND] = 1'b0;
            end
            default: ;
         endcase
      end
      // transmit engine
      if (tsel) begin
         n.town = 1'b1;
         if (s.tstuff && s.tones == 3'd5) begin
            n.tbit = 1'b0;
            n.tones = 3'd0;
         end else begin
            if (tcnt == 4'd0) begin
               tcnt = 4'd8;
               st = 1'b1;
               case (s.tst)
                  TS_IDLE: begin
                     sh = hlc_pkg::FLAG_OCT;
                     st = 1'b0;
                     if (s.txc != 0) begin
                        n.tst = TS_DATA;
                        n.tcrc = hlc_pkg::CRC_INIT;
                     end
                  end
                  TS_DATA: begin
                     if (s.txc == 0) begin
                        sh = hlc_pkg::ABORT_OCT;  // underrun: abort the frame
                        st = 1'b0;
                        n.tst = TS_IDLE;
                        ev_t[hlc_pkg::T_UDR] = 1'b1;
                     end else begin
                        sh = s.txm[s.txr][7:0];
                        tpop = 1'b1;
                        n.tcrc = crc8(s.tcrc, s.txm[s.txr][7:0]);
                        if (s.txm[s.txr][8]) n.tst = TS_CRC1;
                     end
                  end
                  TS_CRC1: begin
                     sh = ~s.tcrc[7:0];
                     n.tst = TS_CRC2;
                  end
                  default: begin
                     sh = ~s.tcrc[15:8];
                     n.tst = TS_IDLE;
                     ev_t[hlc_pkg::T_SENT] = 1'b1;
                  end
               endcase
            end
            n.tbit = sh[0];
            n.tones = (st && sh[0]) ? s.tones + 3'd1 : 3'd0;
            n.tsh = sh >> 1;
            n.tn = tcnt - 4'd1;
            n.tstuff = st;
         end
      end else begin
         n.town = 1'b0;
      end
      // fifo bookkeeping
      if (push) n.rxm[s.rxw] = {pend, pb};
      if (tpush) n.txm[s.txw] = {s.tc1[hlc_pkg::B_TXEND], reg_wdata_in};
      n.rxw = s.rxw + AW'(push);
      n.rxr = s.rxr + AW'(pop);
      n.rxc = s.rxc + (AW+1)'(push) - (AW+1)'(pop);
      n.txw = s.txw + AW'(tpush);
      n.txr = s.txr + AW'(tpop);
      n.txc = s.txc + (AW+1)'(tpush) - (AW+1)'(tpop);
      if (push && !pop && s.rxc == (AW+1)'(DEPTH)) begin
         // overrun: drop packet and everything queued
         n.rxr = s.rxw;
         n.rxw = s.rxw;
         n.rxc = '0;
         n.rin = 1'b0;
         n.ovr_hold = 1'b1;
         ev_r[hlc_pkg::R_OVR] = 1'b1;
      end
      // watermark rising edges as latched events
      n.hwm_prev = hwm_now;
      n.lwm_prev = lwm_now;
      if (hwm_now && !s.hwm_prev) ev_r[hlc_pkg::R_HWM] = 1'b1;
      if (lwm_now && !s.lwm_prev) ev_t[hlc_pkg::T_LWM] = 1'b1;
      // set wins over a same-cycle clear
      n.rls = n.rls | ev_r;
      n.tls = n.tls | ev_t;
      n.rack = n.rack & n.rls & ~ev_r;
      n.tack = n.tack & n.tls & ~ev_t;
      n.irq_n = ~|((n.rls & s.rim & ~n.rack) | (n.tls & s.tim & ~n.tack));
      if (sys_rst_in) begin
         n = '0;
         n.rctl = hlc_pkg::RST_CTRL;
         n.tc2 = hlc_pkg::RST_CTRL;
         n.rfc = hlc_pkg::RST_RFC;
         n.tfc = hlc_pkg::RST_TFC;
         n.rim = hlc_pkg::RST_MASK;
         n.tim = hlc_pkg::RST_MASK;
         n.rcrc = hlc_pkg::CRC_INIT;
         n.rones = 3'd7;  // hunt for a flag
         n.irq_n = 1'b1;
         n.tst = TS_IDLE;
      end
   end

   // single state register, reset folded into next state
   always_ff @(posedge mclk_in) begin
      s <= n;
   end

   assign reg_rdata_out   = s.rdat;
   assign irq_n_out       = s.irq_n;
   assign tx_line_bit_out = s.tbit;
   assign tx_line_own_out = s.town;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);

   a_rx_hwm_read: assert property ((reg_rd_in && reg_addr_in == hlc_pkg::A_RRT) |=>
      reg_rdata_out[hlc_pkg::R_HWM] == ($past(s.rxc) > $past(s.rfc[AW-1:0])))
      else $error("rx watermark bit wrong");
   a_tx_lwm_read: assert property ((reg_rd_in && reg_addr_in == hlc_pkg::A_TRT) |=>
      reg_rdata_out[hlc_pkg::T_LWM] == ($past(s.txc) < $past(s.tfc[AW-1:0])))
      else $error("tx watermark bit wrong");
   a_tx_free_count: assert property ((reg_rd_in && reg_addr_in == hlc_pkg::A_TAVL) |=>
      reg_rdata_out == 8'(DEPTH - $past(s.txc))) else $error("tx free count wrong");
   a_rx_count_bound: assert property ((reg_rd_in && reg_addr_in == hlc_pkg::A_RPBA) |=>
      reg_rdata_out[6:0] <= 7'($past(s.rxc))) else $error("rx count above level");
   a_ovr_flush: assert property (ev_r[hlc_pkg::R_OVR] |=> s.rxc == 0 && s.ovr_hold
      && s.rls[hlc_pkg::R_OVR]) else $error("overrun did not flush");
   a_latch_set: assert property ((|ev_r) |=> (s.rls & $past(ev_r)) == $past(ev_r))
      else $error("event not latched");
   a_w1c_clear: assert property ((reg_wr_in && reg_addr_in == hlc_pkg::A_RLS && ev_r == 0) |=>
      s.rls == ($past(s.rls) & ~$past(reg_wdata_in))) else $error("clear wrong");
   // a host read or clear of the latched bits may release the pin in the same cycle
   a_irq_assert: assert property ((|(s.rls & s.rim & ~s.rack))
      && !((reg_rd_in || reg_wr_in) && reg_addr_in == hlc_pkg::A_RLS) |=> !irq_n_out)
      else $error("interrupt not driven");
   a_irq_release: assert property ((s.rls & s.rim & ~s.rack) == 0 && (s.tls & s.tim & ~s.tack) == 0
      && ev_r == 0 && ev_t == 0 |=> irq_n_out) else $error("interrupt stuck");
   a_tx_stuff_zero: assert property ((tsel && s.tstuff && s.tones == 3'd5) |=>
      !tx_line_bit_out && tx_line_own_out) else $error("no stuffed zero");
   c_rx_good: cover property (ev_r[hlc_pkg::R_END]);
   c_rx_abort: cover property (ev_r[hlc_pkg::R_ABT]);
   c_rx_ovr: cover property (ev_r[hlc_pkg::R_OVR]);
   c_tx_sent: cover property (ev_t[hlc_pkg::T_SENT]);
endmodule // hlc_link_ctrl
`default_nettype wire

// file: design/hlc_pkg.sv
// Function
// - map to slot, E1 Sa4-Sa8, or T1 FDL
// - 64-byte FIFO each in transmit and receive
// - per-bit include/exclude of slot bits, Sa bits
// - flags, FCS generate/check, abort generate/detect
// - zero stuffing, destuffing, receive byte alignment
// - rx high and tx low watermark registers
// - rx high-watermark bit while level above mark
// - tx low-watermark bit while level below mark
// - overrun drops packet, empties FIFO, flags both
// - low 7 bits give readable bytes 0-64
// - each count covers exactly one packet segment
// - msb set while counted packet not terminated
// - latched bit sets on event, holds until cleared
// - write one clears; zeros, real-time bits untouched
// - real-time bits show present condition only
// - every latched event has own mask bit
// - interrupt released when host reads event bit
// - tx free count real time, stable during read
`default_nettype none
package hlc_pkg;
   // register offsets
   localparam logic [8:0] A_RCTL = 9'h010;
   localparam logic [8:0] A_RBS  = 9'h011;
   localparam logic [8:0] A_RFC  = 9'h087;
   localparam logic [8:0] A_RLS  = 9'h094;
   localparam logic [8:0] A_RIM  = 9'h0a4;
   localparam logic [8:0] A_RRT  = 9'h0b4;
   localparam logic [8:0] A_RPBA = 9'h0b5;
   localparam logic [8:0] A_RFD  = 9'h0b6;
   localparam logic [8:0] A_TC1  = 9'h110;
   localparam logic [8:0] A_TBS  = 9'h111;
   localparam logic [8:0] A_TC2  = 9'h113;
   localparam logic [8:0] A_TFC  = 9'h187;
   localparam logic [8:0] A_TLS  = 9'h191;
   localparam logic [8:0] A_TIM  = 9'h1a1;
   localparam logic [8:0] A_TRT  = 9'h1b1;
   localparam logic [8:0] A_TAVL = 9'h1b3;
   localparam logic [8:0] A_TFD  = 9'h1b4;
   // control fields
   localparam int B_MAPSEL = 7;  // 1: Sa bits (E1) or FDL (T1)
   localparam int B_TXEND  = 0;  // next tx byte closes packet
   // rx status bits
   localparam int R_END  = 0;  // good packet end (latched)
   localparam int R_HWM  = 1;  // high watermark
   localparam int R_CRC  = 2;  // bad crc or misaligned
   localparam int R_ABT  = 3;  // abort seen
   localparam int R_STRT = 4;  // packet start
   localparam int R_OVR  = 5;  // overrun
   localparam int R_NE   = 0;  // real-time: fifo not empty
   // tx status bits
   localparam int T_UDR  = 0;  // underrun, frame aborted
   localparam int T_LWM  = 1;  // low watermark
   localparam int T_SENT = 2;  // frame finished
   localparam int T_EMP  = 0;  // real-time: fifo empty
   // reset values
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_RFC  = 8'h20;
   localparam logic [7:0] RST_TFC  = 8'h10;
   localparam logic [7:0] RST_MASK = 8'h00;
   // line coding
   localparam logic [7:0]  FLAG_OCT  = 8'h7e;
   localparam logic [7:0]  ABORT_OCT = 8'hff;
   localparam logic [15:0] CRC_INIT  = 16'hffff;
   localparam logic [15:0] CRC_POLY  = 16'h8408;
   localparam logic [15:0] CRC_GOOD  = 16'hf0b8;
   localparam int          FIFO_DEPTH = 64;
endpackage : hlc_pkg
`default_nettype wire

// file: test/hlc_line_model.sv
`default_nettype none
// framer side: four-slot frame with the block's own bits looped back to its receiver
module hlc_line_model (
   input  wire logic       mclk_in,      // bench clock
   input  wire logic       sys_rst_in,   // sync reset, high
   input  wire logic       run_in,       // let line bit times flow
   input  wire logic       tx_bit_in,    // bit offered by the block
   input  wire logic       tx_own_in,    // block owned the last bit
   output var  logic       bit_stb_out,  // one line bit time
   output var  logic [4:0] slot_out,     // time slot, 0..3 only
   output var  logic [2:0] bit_pos_out,  // bit inside the slot
   output var  logic       rx_bit_out    // looped bit for the receiver
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       div_q;  // strobe on every other cycle
   logic [4:0] cnt_q;  // slot and bit position together
   // a short frame keeps each owned bit only 64 cycles apart
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         div_q       <= 1'b0;
         cnt_q       <= 5'h00;
         bit_stb_out <= 1'b0;
         rx_bit_out  <= 1'b1;
      end else begin
         div_q       <= ~div_q;
         bit_stb_out <= run_in & ~div_q;
         // counters move with the strobe so they are stable while it is high
         if (run_in && !div_q) begin
            cnt_q <= cnt_q + 5'h01;
         end
         // one bit of delay in the loop, harmless to the framing
         if (tx_own_in) begin
            rx_bit_out <= tx_bit_in;
         end
      end
   end
   assign slot_out    = {3'h0, cnt_q[4:3]};
   assign bit_pos_out = cnt_q[2:0];
endmodule // hlc_line_model
`default_nettype wire

// file: test/hlc_link_ctrl_test.sv
`default_nettype none
module hlc_link_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk_in, sys_rst_in, reg_wr_in, reg_rd_in;  // clock, reset, strobes
   logic       run, stb, rxb, txb, own, irq_n;              // line and interrupt
   logic [8:0] reg_addr_in;                                  // register address
   logic [7:0] reg_wdata_in, rdata, v;                       // bus data
   logic [4:0] slot;                                         // current slot
   logic [2:0] pos;                                          // bit in slot
   int         miscompares, total_checks, cycles, seed, n;  // bookkeeping
   logic [7:0] q[$];                                         // bytes expected back
   logic [8:0] ra[12] = '{hlc_pkg::A_RCTL, hlc_pkg::A_RBS, hlc_pkg::A_RFC, hlc_pkg::A_RIM, hlc_pkg::A_TC2,
      hlc_pkg::A_TFC, hlc_pkg::A_TIM, hlc_pkg::A_RLS, hlc_pkg::A_RRT, hlc_pkg::A_TRT, hlc_pkg::A_TAVL, 9'h000};
   logic [7:0] rv[12] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h03, 8'h40, 8'h00};
   logic [7:0] rm[12] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff};
   logic [8:0] rw[6] = '{hlc_pkg::A_RCTL, hlc_pkg::A_RBS, hlc_pkg::A_RIM, hlc_pkg::A_TC2, hlc_pkg::A_TBS,
      hlc_pkg::A_TIM};

   hlc_link_ctrl dut_u (
      .mclk_in         (mclk_in),
      .sys_rst_in      (sys_rst_in),
      .reg_addr_in     (reg_addr_in),
      .reg_wdata_in    (reg_wdata_in),
      .reg_wr_in       (reg_wr_in),
      .reg_rd_in       (reg_rd_in),
      .reg_rdata_out   (rdata),
      .irq_n_out       (irq_n),
      .e1_mode_in      (1'b1),
      .bit_stb_in      (stb),
      .slot_in         (slot),
      .bit_pos_in      (pos),
      .sa_num_in       (4'h0),
      .fdl_in          (1'b0),
      .rx_line_bit_in  (rxb),
      .tx_line_bit_out (txb),
      .tx_line_own_out (own)
   );

   hlc_line_model line_u (
      .mclk_in     (mclk_in),
      .sys_rst_in  (sys_rst_in),
      .run_in      (run),
      .tx_bit_in   (txb),
      .tx_own_in   (own),
      .bit_stb_out (stb),
      .slot_out    (slot),
      .bit_pos_out (pos),
      .rx_bit_out  (rxb)
   );

   // free-running clock, 25 ns period
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   // one-cycle write strobe
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      reg_wr_in    <= 1'b1;
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask

   // one-cycle read strobe; data is taken only in the following cycle
   task automatic rd(input logic [8:0] a, output logic [7:0] d);
      @(posedge mclk_in);
      reg_rd_in   <= 1'b1;
      reg_addr_in <= a;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      #1 d = rdata;
   endtask

   // register value against expectation under a mask
   task automatic chk(input logic [8:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      rd(a, d);
      total_checks++;
      if ((d & m) !== (e & m)) begin
         miscompares++;
         $display("unexpected at %0t: reg %h read %h want %h", $time, a, d, e);
      end
   endtask

   // interrupt pin level
   task automatic chk_irq(input logic e);
      total_checks++;
      if (irq_n !== e) begin
         miscompares++;
         $display("unexpected at %0t: interrupt pin %b want %b", $time, irq_n, e);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // hang guard, far above the roughly 600 cycles one frame needs
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      sys_rst_in   = 1'b1;
      reg_wr_in    = 1'b0;
      reg_rd_in    = 1'b0;
      reg_addr_in  = 9'h000;
      reg_wdata_in = 8'h00;
      run          = 1'b0;
      seed         = 71635;
      repeat (4) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      // reset values, empty fifos, unmapped address reads zero
      foreach (ra[i]) chk(ra[i], rm[i], rv[i]);
      chk_irq(1'b1);
      // random read-back of plain control registers, then put back to zero
      foreach (rw[i]) begin
         v = 8'($random(seed));
         wr(rw[i], v);
         chk(rw[i], 8'hff, v);
         wr(rw[i], 8'h00);
      end
      // both directions on slot 2, receive mark at 2 bytes, good-end unmasked
      wr(hlc_pkg::A_RFC, 8'h02);
      wr(hlc_pkg::A_RCTL, 8'h02);
      wr(hlc_pkg::A_TC2, 8'h02);
      wr(hlc_pkg::A_RIM, 8'h01);
      // four random bytes, the last closing the packet; line held still meanwhile
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         q.push_back(v);
         if (i == 3) wr(hlc_pkg::A_TC1, 8'h01);
         wr(hlc_pkg::A_TFD, v);
      end
      chk(hlc_pkg::A_TAVL, 8'hff, 8'(64 - q.size()));
      chk(hlc_pkg::A_TRT, 8'h03, 8'h02);
      @(posedge mclk_in);
      run <= 1'b1;
      // frame goes out, loops back, good end raises the interrupt
      n = 0;
      while (irq_n !== 1'b0 && n < 20000) begin
         @(posedge mclk_in);
         n++;
      end
      chk_irq(1'b0);
      chk(hlc_pkg::A_RPBA, 8'hff, 8'(q.size()));
      chk(hlc_pkg::A_RRT, 8'h03, 8'h03);
      chk(hlc_pkg::A_RLS, 8'h1d, 8'h11);
      repeat (2) @(posedge mclk_in);
      chk_irq(1'b1);
      // clear good end only; packet start must survive
      wr(hlc_pkg::A_RLS, 8'h01);
      chk(hlc_pkg::A_RLS, 8'h1d, 8'h10);
      // payload back intact after destuffing and byte alignment
      while (q.size() > 0) chk(hlc_pkg::A_RFD, 8'hff, q.pop_front());
      chk(hlc_pkg::A_RRT, 8'h03, 8'h00);
      chk(hlc_pkg::A_TRT, 8'h03, 8'h03);
      chk(hlc_pkg::A_TAVL, 8'hff, 8'h40);
      end_of_test();
   end
endmodule // hlc_link_ctrl_test
`default_nettype wire
